// ### rvl_pkg.sv
// Package: constants, register map and carriers of the relay, link and comparator block
package rvl_pkg;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 8;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

  // ***********************************************************
  // Sizes
  // ***********************************************************
  localparam int N_MAIN_RELAY = 3;
  localparam int RELAYS_PER_BOARD = 3;
  localparam int N_BOARD = 2;
  localparam int N_RELAY = N_MAIN_RELAY + RELAYS_PER_BOARD * N_BOARD;
  localparam int N_VLINK = 8;
  localparam int N_CMP = 4;
  localparam int N_ANALOG = 16;
  localparam int EXT_N = 48;
  localparam int N_SRC = 64;
  localparam int N_FUNC = 64;
  localparam int SEL_W = 6;
  localparam int ASEL_W = 4;
  localparam int VAL_W = 16;
  localparam int DLY_W = 19;
  localparam int REM_W = 7;

  localparam logic [DLY_W-1:0] DLY_MAX = 19'h57E3F;
  localparam logic [REM_W-1:0] TICK_MS_W = 7'h08;
  localparam logic [REM_W-1:0] MS_PER_TENTH = 7'h64;

  // ***********************************************************
  // Signal codes and defaults
  // ***********************************************************
  localparam logic [SEL_W-1:0] SRC_OFF = 6'h00;
  localparam logic [SEL_W-1:0] SRC_TRIP = 6'h01;
  localparam logic [SEL_W-1:0] SRC_OPERATION = 6'h02;
  localparam int SRC_EXT_BASE = 1;
  localparam int SRC_CA_BASE = 49;
  localparam int SRC_CAN_BASE = 53;
  localparam int SRC_CD_BASE = 57;
  localparam logic [SEL_W-1:0] FUNC_OFF = 6'h00;
  localparam logic [ASEL_W-1:0] ASEL_CURRENT = 4'h4;
  localparam logic [VAL_W-1:0] HI_DEF = 16'h012C;
  localparam logic [VAL_W-1:0] LO_DEF = 16'h00C8;

  typedef enum logic {CMP_HYST = 1'b0, CMP_WINDOW = 1'b1} rvl_cmp_type_e;

  // ***********************************************************
  // Register map
  // ***********************************************************
  localparam logic [11:0] OFF_RELAY_FUNC = 12'h000;
  localparam logic [11:0] OFF_RELAY_MODE = 12'h024;
  localparam logic [11:0] OFF_STATUS = 12'h028;
  localparam logic [11:0] OFF_VLINK = 12'h040;
  localparam logic [11:0] OFF_ACMP = 12'h080;
  localparam logic [11:0] OFF_DCMP = 12'h100;
  localparam logic [4:0] FO_CFG = 5'h00;
  localparam logic [4:0] FO_LEVELS = 5'h04;
  localparam logic [4:0] FO_SETDLY = 5'h08;
  localparam logic [4:0] FO_RSTDLY = 5'h0C;
  localparam logic [4:0] FO_TIMER = 5'h10;
  localparam int VL_DST_LSB = 8;
  localparam int ACMP_TYPE_BIT = 8;
  localparam int LO_LSB = 16;
  localparam int ST_CAN_LSB = 4;
  localparam int ST_CD_LSB = 8;
  localparam int ST_BOARD_LSB = 12;
  localparam int ST_RELAY_LSB = 16;

  // ***********************************************************
  // Carriers
  // ***********************************************************
  typedef struct packed {
    logic [ASEL_W-1:0] sel;
    rvl_cmp_type_e kind;
    logic [VAL_W-1:0] hi;
    logic [VAL_W-1:0] lo;
    logic [DLY_W-1:0] set_dly;
    logic [DLY_W-1:0] rst_dly;
  } rvl_acmp_cfg_s;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [DLY_W-1:0] set_dly;
    logic [DLY_W-1:0] rst_dly;
  } rvl_dcmp_cfg_s;

  typedef struct packed {
    logic q;
    logic [DLY_W-1:0] tenths;
    logic [REM_W-1:0] rem;
  } rvl_dly_s;

endpackage : rvl_pkg

// ### rvl_top.sv
// Relay routing, virtual links and comparators with an AHB-Lite register slave
//
// Notes on behaviour
// - Relay 3 picks its function from the relay list; default is trip.
// - Six board relays, three per slot, default off, dead unless board detected.
// - Mode 0 normal-open; mode 1 inverts the coil so NC acts as NO.
// - Eight virtual links route an output signal to an input function.
// - Each link destination picks an input function; default off.
// - Each link source picks from the relay signal list; default off.
// - An input function is the OR of physical request and every link.
// - Comparators and delay timers are evaluated once per 8 ms tick.
// - Four analogue comparators, each against upper and lower threshold.
// - Analogue selector codes 0 to 15, default current, code 4.
// - Hysteresis: above upper threshold sets output, clears complement.
// - Hysteresis: below lower threshold clears output, sets complement.
// - Hysteresis: between thresholds the output holds its last state.
// - Lower above upper is accepted and makes the hysteresis output latch.
// - Window: strictly between thresholds drives output high.
// - Window: outside the band drives output low, complement high.
// - Four digital comparators each watch one selectable signal.
// - Every comparator has set delay, reset delay and readable timer.
// - Comparator outputs are selectable by relays and virtual links.
// - Comparator type code 0 hysteresis, 1 window; default hysteresis.
// - Delays 0 to 9:59:59.9 in tenths of seconds, default zero.
// - Digital comparator output is high while its input is active.
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
module rvl_top
  import rvl_pkg::*;
#(
  parameter int TICK_CYCLES = rvl_pkg::TICK_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [rvl_pkg::N_ANALOG-1:0][rvl_pkg::VAL_W-1:0] analog_values,
  input wire logic [rvl_pkg::EXT_N-1:0] ext_signals,
  input wire logic [rvl_pkg::N_BOARD-1:0] board_present,
  input wire logic [rvl_pkg::N_FUNC-1:0] input_func_req,
  output logic [rvl_pkg::N_RELAY-1:0] relay_out,
  output logic [rvl_pkg::N_FUNC-1:0] func_active,
  output logic [rvl_pkg::N_CMP-1:0] analog_cmp_out,
  output logic [rvl_pkg::N_CMP-1:0] analog_cmp_out_n,
  output logic [rvl_pkg::N_CMP-1:0] digital_cmp_out
);
  import rvl_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  // ***********************************************************
  // Functions
  // ***********************************************************
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [31:0] w);
    clamp_dly = (w[31:DLY_W] != '0 || w[DLY_W-1:0] > DLY_MAX) ? DLY_MAX : w[DLY_W-1:0];
  endfunction : clamp_dly

  // One tick of a set/reset delay stage
  function automatic rvl_dly_s dly_step(input rvl_dly_s s, input logic raw,
                                        input logic [DLY_W-1:0] set_d,
                                        input logic [DLY_W-1:0] rst_d);
    rvl_dly_s n;
    logic [DLY_W-1:0] lim;
    logic [REM_W-1:0] r;
    n = s;
    lim = raw ? set_d : rst_d;
    r = s.rem + TICK_MS_W;
    if (raw == s.q) begin
      n.tenths = '0;
      n.rem = '0;
    end else if (lim == '0) begin
      n.q = raw;
    end else begin
      if (r >= MS_PER_TENTH) begin
        n.rem = r - MS_PER_TENTH;
        n.tenths = s.tenths + 1'b1;
      end else begin
        n.rem = r;
      end
      if (n.tenths >= lim) begin
        n.q = raw;
        n.tenths = '0;
        n.rem = '0;
      end
    end
    dly_step = n;
  endfunction : dly_step

  // ***********************************************************
  // State
  // ***********************************************************
  logic [SEL_W-1:0] relay_func [N_RELAY];
  logic [N_RELAY-1:0] relay_mode;
  logic [SEL_W-1:0] vl_src [N_VLINK];
  logic [SEL_W-1:0] vl_dst [N_VLINK];
  rvl_acmp_cfg_s acmp [N_CMP];
  rvl_dcmp_cfg_s dcmp [N_CMP];
  rvl_dly_s ca_dly [N_CMP];
  rvl_dly_s cd_dly [N_CMP];
  logic [N_CMP-1:0] hyst_q;
  logic [N_CMP-1:0] can_q;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic wr_pend;
  logic rd_pend;
  logic [11:0] addr_q;

  logic [N_SRC-1:0] src;
  logic [N_CMP-1:0] next_hyst;
  rvl_dly_s next_ca [N_CMP];
  rvl_dly_s next_cd [N_CMP];
  logic [N_RELAY-1:0] next_relay;
  logic [N_FUNC-1:0] next_func;
  logic [31:0] rd_mux;
  logic accept;

  // ***********************************************************
  // Update tick
  // ***********************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ***********************************************************
  // Signal list
  // ***********************************************************
  always_comb begin
    src = '0;
    src[SRC_EXT_BASE +: EXT_N] = ext_signals;
    for (int i = 0; i < N_CMP; i++) begin
      src[SRC_CA_BASE + i] = ca_dly[i].q;
      src[SRC_CAN_BASE + i] = ~ca_dly[i].q;
      src[SRC_CD_BASE + i] = cd_dly[i].q;
    end
    src[SRC_OFF] = 1'b0;
  end

  // ***********************************************************
  // Comparators
  // ***********************************************************
  always_comb begin
    logic [VAL_W-1:0] v;
    logic above;
    logic below;
    logic raw;
    v = '0;
    above = 1'b0;
    below = 1'b0;
    raw = 1'b0;
    for (int i = 0; i < N_CMP; i++) begin
      v = analog_values[acmp[i].sel];
      above = $signed(v) > $signed(acmp[i].hi);
      below = $signed(v) < $signed(acmp[i].lo);
      next_hyst[i] = hyst_q[i];
      if (above) begin
        next_hyst[i] = 1'b1;
      end else if (below && !($signed(acmp[i].lo) > $signed(acmp[i].hi))) begin
        next_hyst[i] = 1'b0;
      end
      if (acmp[i].kind == CMP_WINDOW) begin
        raw = $signed(v) > $signed(acmp[i].lo) && $signed(v) < $signed(acmp[i].hi);
      end else begin
        raw = next_hyst[i];
      end
      next_ca[i] = dly_step(ca_dly[i], raw, acmp[i].set_dly, acmp[i].rst_dly);
      next_cd[i] = dly_step(cd_dly[i], src[dcmp[i].sel], dcmp[i].set_dly,
                            dcmp[i].rst_dly);
    end
  end

  // Comparator and delay state moves only on the tick, so the comparator entries of the shared list stay consistent for a period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hyst_q <= '0;
      for (int i = 0; i < N_CMP; i++) begin
        ca_dly[i] <= '0;
        cd_dly[i] <= '0;
      end
    end else if (tick) begin
      hyst_q <= next_hyst;
      for (int i = 0; i < N_CMP; i++) begin
        ca_dly[i] <= next_ca[i];
        cd_dly[i] <= next_cd[i];
      end
    end
  end

  // ***********************************************************
  // Relays and virtual links
  // ***********************************************************
  always_comb begin
    logic vis;
    logic [N_FUNC-1:0] link_req;
    vis = 1'b0;
    link_req = '0;
    for (int r = 0; r < N_RELAY; r++) begin
      vis = (r < N_MAIN_RELAY) ? 1'b1 : board_present[(r - N_MAIN_RELAY) / RELAYS_PER_BOARD];
      next_relay[r] = vis & (src[relay_func[r]] ^ relay_mode[r]);
    end
    for (int k = 0; k < N_VLINK; k++) begin
      link_req[vl_dst[k]] = link_req[vl_dst[k]] | src[vl_src[k]];
    end
    next_func = input_func_req | link_req;
    next_func[FUNC_OFF] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_out <= '0;
      func_active <= '0;
    end else begin
      relay_out <= next_relay;
      func_active <= next_func;
    end
  end

  assign analog_cmp_out = {ca_dly[3].q, ca_dly[2].q, ca_dly[1].q, ca_dly[0].q};
  // Complement comes from its own flop so the port is not a gate output
  assign analog_cmp_out_n = can_q;
  assign digital_cmp_out = {cd_dly[3].q, cd_dly[2].q, cd_dly[1].q, cd_dly[0].q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      can_q <= '1;
    end else if (tick) begin
      for (int i = 0; i < N_CMP; i++) begin
        can_q[i] <= ~next_ca[i].q;
      end
    end
  end

  // ***********************************************************
  // AHB-Lite slave
  // ***********************************************************
  assign accept = hsel & hready & htrans[1];

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= 1'b0;
    end else begin
      wr_pend <= accept & hwrite;
      rd_pend <= accept & ~hwrite;
      if (accept) begin
        addr_q <= haddr[11:0];
      end
      if (accept & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        hreadyout <= 1'b1;
        hrdata <= rd_mux;
      end
    end
  end

  always_comb begin
    logic [1:0] i;
    i = addr_q[6:5];
    rd_mux = '0;
    if (addr_q < OFF_RELAY_MODE && addr_q[1:0] == 2'b00) begin
      rd_mux[SEL_W-1:0] = relay_func[addr_q[5:2]];
    end else if (addr_q == OFF_RELAY_MODE) begin
      rd_mux[N_RELAY-1:0] = relay_mode;
    end else if (addr_q == OFF_STATUS) begin
      rd_mux[N_CMP-1:0] = analog_cmp_out;
      rd_mux[ST_CAN_LSB +: N_CMP] = analog_cmp_out_n;
      rd_mux[ST_CD_LSB +: N_CMP] = digital_cmp_out;
      rd_mux[ST_BOARD_LSB +: N_BOARD] = board_present;
      rd_mux[ST_RELAY_LSB +: N_RELAY] = relay_out;
    end else if (addr_q[11:5] == OFF_VLINK[11:5] && addr_q[1:0] == 2'b00) begin
      rd_mux[SEL_W-1:0] = vl_src[addr_q[4:2]];
      rd_mux[VL_DST_LSB +: SEL_W] = vl_dst[addr_q[4:2]];
    end else if (addr_q[11:7] == OFF_ACMP[11:7]) begin
      unique case (addr_q[4:0])
        FO_CFG: rd_mux[ACMP_TYPE_BIT:0] = {acmp[i].kind, 4'h0, acmp[i].sel};
        FO_LEVELS: rd_mux = {acmp[i].lo, acmp[i].hi};
        FO_SETDLY: rd_mux[DLY_W-1:0] = acmp[i].set_dly;
        FO_RSTDLY: rd_mux[DLY_W-1:0] = acmp[i].rst_dly;
        FO_TIMER: rd_mux[DLY_W-1:0] = ca_dly[i].tenths;
        default: rd_mux = '0;
      endcase
    end else if (addr_q[11:7] == OFF_DCMP[11:7]) begin
      unique case (addr_q[4:0])
        FO_CFG: rd_mux[SEL_W-1:0] = dcmp[i].sel;
        FO_SETDLY: rd_mux[DLY_W-1:0] = dcmp[i].set_dly;
        FO_RSTDLY: rd_mux[DLY_W-1:0] = dcmp[i].rst_dly;
        FO_TIMER: rd_mux[DLY_W-1:0] = cd_dly[i].tenths;
        default: rd_mux = '0;
      endcase
    end
  end

  // ***********************************************************
  // Register writes
  // ***********************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int r = 0; r < N_RELAY; r++) begin
        relay_func[r] <= SRC_OFF;
      end
      relay_func[2] <= SRC_TRIP;
      relay_mode <= '0;
      for (int k = 0; k < N_VLINK; k++) begin
        vl_src[k] <= SRC_OFF;
        vl_dst[k] <= FUNC_OFF;
      end
      for (int i = 0; i < N_CMP; i++) begin
        acmp[i] <= '{sel: ASEL_CURRENT, kind: CMP_HYST, hi: HI_DEF, lo: LO_DEF,
                     set_dly: '0, rst_dly: '0};
        dcmp[i] <= '{sel: SRC_OPERATION, set_dly: '0, rst_dly: '0};
      end
    end else if (wr_pend) begin
      if (addr_q < OFF_RELAY_MODE && addr_q[1:0] == 2'b00) begin
        relay_func[addr_q[5:2]] <= hwdata[SEL_W-1:0];
      end else if (addr_q == OFF_RELAY_MODE) begin
        relay_mode <= hwdata[N_RELAY-1:0];
      end else if (addr_q[11:5] == OFF_VLINK[11:5] && addr_q[1:0] == 2'b00) begin
        vl_src[addr_q[4:2]] <= hwdata[SEL_W-1:0];
        vl_dst[addr_q[4:2]] <= hwdata[VL_DST_LSB +: SEL_W];
      end else if (addr_q[11:7] == OFF_ACMP[11:7]) begin
        unique case (addr_q[4:0])
          FO_CFG: begin
            acmp[addr_q[6:5]].sel <= hwdata[ASEL_W-1:0];
            acmp[addr_q[6:5]].kind <= rvl_cmp_type_e'(hwdata[ACMP_TYPE_BIT]);
          end
          FO_LEVELS: begin
            acmp[addr_q[6:5]].hi <= hwdata[VAL_W-1:0];
            acmp[addr_q[6:5]].lo <= hwdata[LO_LSB +: VAL_W];
          end
          FO_SETDLY: acmp[addr_q[6:5]].set_dly <= clamp_dly(hwdata);
          FO_RSTDLY: acmp[addr_q[6:5]].rst_dly <= clamp_dly(hwdata);
          default: ;
        endcase
      end else if (addr_q[11:7] == OFF_DCMP[11:7]) begin
        unique case (addr_q[4:0])
          FO_CFG: dcmp[addr_q[6:5]].sel <= hwdata[SEL_W-1:0];
          FO_SETDLY: dcmp[addr_q[6:5]].set_dly <= clamp_dly(hwdata);
          FO_RSTDLY: dcmp[addr_q[6:5]].rst_dly <= clamp_dly(hwdata);
          default: ;
        endcase
      end
    end
  end

endmodule : rvl_top

// ### rvl_top_note_end.sv
// Spare source file: holds no logic

// ### rvl_top_monitor.sv
// Checker bound to rvl_top: bus timing, comparator and routing outputs
module rvl_top_monitor
  import rvl_pkg::*;
#(
  parameter int TICK_CYCLES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [rvl_pkg::N_BOARD-1:0] board_present,
  input wire logic [rvl_pkg::N_FUNC-1:0] input_func_req,
  input wire logic [rvl_pkg::N_RELAY-1:0] relay_out,
  input wire logic [rvl_pkg::N_FUNC-1:0] func_active,
  input wire logic [rvl_pkg::N_CMP-1:0] analog_cmp_out,
  input wire logic [rvl_pkg::N_CMP-1:0] analog_cmp_out_n,
  input wire logic [rvl_pkg::N_CMP-1:0] digital_cmp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Tick phase
  // ****************
  int cnt;
  int ph;
  logic ph_seen;
  logic [11:0] prev_o;
  logic chg;
  logic req;
  assign chg = {analog_cmp_out, analog_cmp_out_n, digital_cmp_out} != prev_o;
  assign req = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      ph <= 0;
      ph_seen <= 1'b0;
      prev_o <= 12'h0F0;
    end else begin
      cnt <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
      prev_o <= {analog_cmp_out, analog_cmp_out_n, digital_cmp_out};
      // First change fixes the tick phase; all later ones must match it
      if (chg && !ph_seen) begin
        ph <= cnt;
        ph_seen <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rd_wait;
    req && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    req && hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_hold;
    !$rose(hreadyout) |-> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_cmp_pair;
    analog_cmp_out_n == ~analog_cmp_out;
  endproperty
  a_cmp_pair: assert property (p_cmp_pair) else $error("complement wrong");
  property p_cmp_tick;
    chg && ph_seen |-> cnt == ph;
  endproperty
  a_cmp_tick: assert property (p_cmp_tick) else $error("change off tick");
  property p_cmp_hold;
    (TICK_CYCLES >= 8) && chg |=> !chg [*7];
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("change within period");
  property p_func0;
    func_active[0] == 1'b0;
  endproperty
  a_func0: assert property (p_func0) else $error("function zero active");
  property p_func_or;
    $past(hresetn) |-> (($past(input_func_req) & ~64'h1 & ~func_active) == 64'h0);
  endproperty
  a_func_or: assert property (p_func_or) else $error("request not passed");
  property p_board_off;
    $past(hresetn) |-> (relay_out[5:3] == 3'h0 || $past(board_present[0]))
      && (relay_out[8:6] == 3'h0 || $past(board_present[1]));
  endproperty
  a_board_off: assert property (p_board_off) else $error("absent board relay on");
  c_read: cover property (req && !hwrite);
  c_ca_rise: cover property ($rose(analog_cmp_out[0]));
  c_window: cover property (analog_cmp_out[1]);
  c_board: cover property (relay_out[3]);
endmodule : rvl_top_monitor

bind rvl_top rvl_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) rvl_top_monitor_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .board_present(board_present),
  .input_func_req(input_func_req), .relay_out(relay_out), .func_active(func_active),
  .analog_cmp_out(analog_cmp_out), .analog_cmp_out_n(analog_cmp_out_n),
  .digital_cmp_out(digital_cmp_out)
);

// ### rvl_plant.sv
// Far-side model: measured quantities, output signals, board detection, input requests
module rvl_plant
  import rvl_pkg::*;
(
  output logic [rvl_pkg::N_ANALOG-1:0][rvl_pkg::VAL_W-1:0] analog_values,
  output logic [rvl_pkg::EXT_N-1:0] ext_signals,
  output logic [rvl_pkg::N_BOARD-1:0] board_present,
  output logic [rvl_pkg::N_FUNC-1:0] input_func_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Levels move only just after a rising edge
  // ****************
  initial begin
    analog_values = '0;
    ext_signals = '0;
    board_present = '0;
    input_func_req = '0;
  end
  task automatic set_an(input int ch, input logic [VAL_W-1:0] v);
    analog_values[ch] <= v;
  endtask : set_an
  task automatic set_ext(input int i, input logic b);
    ext_signals[i] <= b;
  endtask : set_ext
  task automatic set_noise(input logic [39:0] v);
    ext_signals[47:8] <= v;
  endtask : set_noise
  task automatic set_board(input logic [N_BOARD-1:0] v);
    board_present <= v;
  endtask : set_board
  task automatic set_req(input int i, input logic b);
    input_func_req[i] <= b;
  endtask : set_req
endmodule : rvl_plant

// ### relay_virtual_link_comparators_tb_top.sv
// Self-checking bench of rvl_top with its far-side model
module relay_virtual_link_comparators_tb_top
  import rvl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Signals and bus master
  // ****************
  localparam int TC = 8;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
  } rvl_exp_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic rsp_n;
  logic [N_ANALOG-1:0][VAL_W-1:0] an;
  logic [EXT_N-1:0] ext;
  logic [N_BOARD-1:0] brd;
  logic [N_FUNC-1:0] req;
  logic [N_FUNC-1:0] func_active;
  logic [N_FUNC-1:0] fa_n;
  logic rdy_n;
  logic [31:0] rd_n;
  logic rd_ph = 1'b0;
  rvl_exp_s exp_q[$];
  rvl_exp_s e;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 28991;
  always #20 hclk = ~hclk;
  // Registered outputs are captured mid-cycle so edge-time reads never race
  always @(negedge hclk) begin
    rdy_n = hreadyout;
    rd_n = hrdata;
    rsp_n = hresp;
    fa_n = func_active;
  end
  rvl_plant rvl_plant_i (.analog_values(an), .ext_signals(ext), .board_present(brd),
    .input_func_req(req));
  rvl_top #(.TICK_CYCLES(TC)) rvl_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .analog_values(an), .ext_signals(ext), .board_present(brd), .input_func_req(req),
    .relay_out(), .func_active(func_active), .analog_cmp_out(), .analog_cmp_out_n(),
    .digital_cmp_out());
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  always @(posedge hclk) begin
    if (rd_ph && rdy_n === 1'b1) begin
      e = exp_q.pop_front();
      check(rd_n & e.m, e.d);
      check(32'(rsp_n), 32'h0);
    end
  end
  task automatic wait_rdy();
    do @(posedge hclk); while (rdy_n !== 1'b1);
  endtask : wait_rdy
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_ph <= !w;
    wait_rdy();
    rd_ph <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
    exp_q.push_back('{d & m, m});
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n * TC) @(posedge hclk);
  endtask : ticks
  task automatic step(input int ch, input int v, input int k, input logic o);
    rvl_plant_i.set_an(ch, 16'(v));
    ticks(4);
    rd(OFF_STATUS, o ? (32'h1 << k) : (32'h10 << k), 32'h11 << k);
  endtask : step
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rvl_plant_i.set_noise(40'({$random(seed), $random(seed)}));
    for (int i = 0; i < 3; i++) rvl_plant_i.set_an(i, 16'($random(seed)));
    for (int r = 0; r < 9; r++) rd(12'(4 * r), (r == 2) ? 32'h1 : 32'h0, 32'hFFFFFFFF);
    rd(OFF_RELAY_MODE, 32'h0, 32'hFFFFFFFF);
    for (int k = 0; k < 8; k++) rd(OFF_VLINK + 12'(4 * k), 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      rd(OFF_ACMP + 12'(32 * i), 32'h4, 32'h10F);
      rd(OFF_ACMP + 12'(32 * i + 4), 32'h00C8012C, 32'hFFFFFFFF);
      rd(OFF_ACMP + 12'(32 * i + 8), 32'h0, 32'hFFFFFFFF);
      rd(OFF_DCMP + 12'(32 * i), 32'h2, 32'h3F);
    end
    wr(12'h300, 32'hFFFFFFFF);
    rd(12'h300, 32'h0, 32'hFFFFFFFF);
    wr(OFF_ACMP, 32'h6);
    wr(OFF_ACMP + 12'h4, 32'h00320064);
    wr(OFF_ACMP + 12'h20, 32'h103);
    wr(OFF_ACMP + 12'h24, 32'h00320064);
    wr(OFF_ACMP + 12'h40, 32'h5);
    wr(OFF_ACMP + 12'h44, 32'h00C80064);
    step(6, 100, 0, 1'b0);
    step(6, 101, 0, 1'b1);
    step(6, 75, 0, 1'b1);
    step(6, 50, 0, 1'b1);
    step(6, 49, 0, 1'b0);
    step(6, 75, 0, 1'b0);
    step(3, 75, 1, 1'b1);
    step(3, 100, 1, 1'b0);
    step(3, 51, 1, 1'b1);
    step(3, 50, 1, 1'b0);
    step(5, 0, 2, 1'b0);
    step(5, 101, 2, 1'b1);
    step(5, 0, 2, 1'b1);
    wr(OFF_RELAY_FUNC, 32'(SRC_CA_BASE));
    wr(OFF_RELAY_MODE, 32'h1);
    wr(OFF_RELAY_FUNC + 12'hC, 32'h1);
    rvl_plant_i.set_ext(0, 1'b1);
    ticks(1);
    rd(OFF_STATUS, 32'h00050000, 32'h000F0000);
    rvl_plant_i.set_board(2'h1);
    ticks(1);
    rd(OFF_STATUS, 32'h000D1000, 32'h000F3000);
    step(6, 101, 0, 1'b1);
    rd(OFF_STATUS, 32'h0, 32'h00010000);
    wr(OFF_VLINK, 32'h0500 | 32'(SRC_CD_BASE));
    wr(OFF_VLINK + 12'h4, 32'h0704);
    rvl_plant_i.set_ext(1, 1'b1);
    ticks(4);
    rd(OFF_STATUS, 32'h100, 32'h100);
    check(32'(fa_n[5]), 32'h1);
    rvl_plant_i.set_req(7, 1'b1);
    ticks(1);
    check(32'(fa_n[7]), 32'h1);
    rvl_plant_i.set_req(7, 1'b0);
    rvl_plant_i.set_ext(3, 1'b1);
    ticks(1);
    check(32'(fa_n[7]), 32'h1);
    rvl_plant_i.set_ext(3, 1'b0);
    ticks(1);
    check(32'(fa_n[7]), 32'h0);
    wr(OFF_DCMP + 12'h20, 32'h3);
    wr(OFF_DCMP + 12'h28, 32'h2);
    // Let one tick drop the output left high by the old source
    ticks(1);
    rvl_plant_i.set_ext(2, 1'b1);
    ticks(14);
    rd(OFF_DCMP + 12'h30, 32'h1, 32'hFFFFFFFF);
    rd(OFF_STATUS, 32'h0, 32'h200);
    ticks(12);
    rd(OFF_STATUS, 32'h200, 32'h200);
    rd(OFF_DCMP + 12'h30, 32'h0, 32'hFFFFFFFF);
    wr(OFF_DCMP + 12'h6C, 32'hFFFFFFFF);
    rd(OFF_DCMP + 12'h6C, 32'h00057E3F, 32'hFFFFFFFF);
    hresetn <= 1'b0;
    ticks(1);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFF_RELAY_FUNC + 12'h8, 32'h1, 32'hFFFFFFFF);
    rd(OFF_DCMP + 12'h6C, 32'h0, 32'hFFFFFFFF);
    rd(OFF_VLINK, 32'h0, 32'hFFFFFFFF);
    complete_run();
  end
  // Whole run needs about a thousand cycles; 25000 leaves ample margin
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
endmodule : relay_virtual_link_comparators_tb_top
